// ---- rtl/ptc_pkg.sv ----
// Package: register map, field positions and timing constants
package ptc_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_ONE_SEC    = 8'h81;
  localparam logic [7:0]  ADDR_SEC_CNT    = 8'h82;
  localparam logic [7:0]  ADDR_NS_CNT     = 8'h83;
  localparam logic [7:0]  ADDR_CFG        = 8'h84;
  localparam logic [7:0]  ADDR_HI_PER     = 8'h85;
  localparam logic [7:0]  ADDR_LO_PER     = 8'h86;
  localparam logic [7:0]  ADDR_START      = 8'h88;
  localparam logic [7:0]  ADDR_FREE_CNT   = 8'h8c;
  localparam logic [7:0]  ADDR_CAPT_LO    = 8'h8d;
  localparam logic [7:0]  ADDR_CAPT_HI    = 8'h8e;
  localparam logic [31:0] ONE_SEC_RESET   = 32'h3b9aca00;
  localparam logic [31:0] ZERO_RESET      = 32'h00000000;
  localparam logic [31:0] NS_STEP         = 32'h00000010;
  localparam int          CFG_ENABLE      = 0;
  localparam int          CFG_CLEAR       = 1;
  localparam int          CFG_IDLE        = 2;
  localparam int          CFG_STOP        = 3;
  localparam int          CFG_FREE_SEL    = 4;
  // Counting clock and mclk rates, in MHz
  localparam int          COUNT_MHZ       = 120;
  localparam int          MCLK_MHZ        = 200;
endpackage : ptc_pkg

// ---- rtl/ptc_rate_div.sv ----
// Fractional divider: one-cycle enable at the counting rate
`timescale 1ns/1ps
`default_nettype none
module ptc_rate_div #(
  parameter int NUM = 120,
  parameter int DEN = 200
) (
  input  wire logic mclk,
  input  wire logic resetn,
  output logic      tick
);
  logic [15:0] acc_reg;
  logic [16:0] sum;

  assign sum = {1'b0, acc_reg} + 17'(NUM);

  // Phase accumulator keeps the average rate exact at NUM/DEN
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (sum >= 17'(DEN)) begin
      acc_reg <= 16'(sum - 17'(DEN));
      tick    <= 1'b1;
    end else begin
      acc_reg <= sum[15:0];
      tick    <= 1'b0;
    end
  end
endmodule // ptc_rate_div
`default_nettype wire

// ---- rtl/ptc_timer.sv ----
// Precision time counter with periodic pulse output
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ptc_timer
  import ptc_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic [ptc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  input  wire logic                     frame_rx,
  output logic                          stamp_valid,
  output logic                          stamp_wide,
  output logic [63:0]                   stamp_value,
  output logic                          periodic_pulse_output
);
  import ptc_pkg::*;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_WAIT = 3'b010,
    PS_RUN  = 3'b100
  } ptc_pstate_t;

  logic [31:0] one_second_compare_reg;
  logic [31:0] seconds_count_reg;
  logic [31:0] nanosecond_count_reg;
  logic [31:0] accum_reg;
  logic [31:0] freerun_reg;
  logic [31:0] pulse_high_period_reg;
  logic [31:0] pulse_low_period_reg;
  logic [31:0] pulse_start_value_reg;
  logic [31:0] phase_reg;
  logic        stamp_counters_enable_reg;
  logic        pulse_idle_level_reg;
  logic        capture_freerun_select_reg;
  logic        frame_stamp_size_select_reg;
  logic        level_reg;
  ptc_pstate_t pstate_reg;
  logic        tick;
  logic        adv;
  logic        wrap;
  logic [31:0] ns_next;
  logic        wr_cfg;
  logic        clear_req;
  logic        stop_req;
  logic        start_req;
  logic [31:0] phase_next;
  logic        idle_next;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b,
                               input logic s);
    return s && (a == b);
  endfunction

  ptc_rate_div #(
    .NUM (COUNT_MHZ),
    .DEN (MCLK_MHZ)
  ) u_div (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (tick)
  );

  assign wr_cfg    = hit(reg_addr, ADDR_CFG, reg_wr);
  assign clear_req = wr_cfg && reg_wdata[CFG_CLEAR];
  assign stop_req  = wr_cfg && reg_wdata[CFG_STOP];
  assign start_req = hit(reg_addr, ADDR_START, reg_wr);
  assign adv       = tick && stamp_counters_enable_reg;
  assign wrap      = (nanosecond_count_reg + NS_STEP)
                     >= one_second_compare_reg;
  // Wrap keeps the residue so a compare off the step grid does not drift
  assign ns_next   = wrap ? nanosecond_count_reg + NS_STEP
                            - one_second_compare_reg
                          : nanosecond_count_reg + NS_STEP;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      one_second_compare_reg <= ONE_SEC_RESET;
      pulse_high_period_reg  <= ZERO_RESET;
      pulse_low_period_reg   <= ZERO_RESET;
      pulse_start_value_reg  <= ZERO_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ONE_SEC)
        one_second_compare_reg <= reg_wdata;
      if (reg_addr == ADDR_HI_PER)
        pulse_high_period_reg <= reg_wdata;
      if (reg_addr == ADDR_LO_PER)
        pulse_low_period_reg <= reg_wdata;
      if (reg_addr == ADDR_START)
        pulse_start_value_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stamp_counters_enable_reg   <= 1'b0;
      capture_freerun_select_reg  <= 1'b0;
      pulse_idle_level_reg        <= 1'b0;
    end else if (wr_cfg) begin
      stamp_counters_enable_reg  <= reg_wdata[CFG_ENABLE];
      capture_freerun_select_reg <= reg_wdata[CFG_FREE_SEL];
      if (pstate_reg == PS_IDLE)
        pulse_idle_level_reg <= reg_wdata[CFG_IDLE];
    end
  end

  // Time counters; clear beats load and count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      nanosecond_count_reg <= ZERO_RESET;
      seconds_count_reg    <= ZERO_RESET;
      accum_reg            <= ZERO_RESET;
      freerun_reg          <= ZERO_RESET;
    end else if (clear_req) begin
      nanosecond_count_reg <= ZERO_RESET;
      seconds_count_reg    <= ZERO_RESET;
      accum_reg            <= ZERO_RESET;
      freerun_reg          <= ZERO_RESET;
    end else begin
      if (adv) begin
        freerun_reg <= freerun_reg + 32'h00000001;
        accum_reg   <= accum_reg + NS_STEP;
      end
      if (hit(reg_addr, ADDR_NS_CNT, reg_wr))
        nanosecond_count_reg <= reg_wdata;
      else if (adv)
        nanosecond_count_reg <= ns_next;
      if (hit(reg_addr, ADDR_SEC_CNT, reg_wr))
        seconds_count_reg <= reg_wdata;
      else if (adv && wrap)
        seconds_count_reg <= seconds_count_reg + 32'h00000001;
    end
  end

  // Frame stamp capture
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stamp_valid <= 1'b0;
      stamp_wide  <= 1'b0;
      stamp_value <= 64'h0000000000000000;
    end else begin
      stamp_valid <= frame_rx && stamp_counters_enable_reg;
      if (frame_rx && stamp_counters_enable_reg) begin
        stamp_wide <= frame_stamp_size_select_reg;
        if (frame_stamp_size_select_reg)
          stamp_value <= {seconds_count_reg,
                          nanosecond_count_reg};
        else if (capture_freerun_select_reg)
          stamp_value <= {32'h00000000, freerun_reg};
        else
          stamp_value <= {32'h00000000, seconds_count_reg[1:0],
                          nanosecond_count_reg[29:0]};
      end
    end
  end

  // Pulse sequencer: waits for the start time, then alternates
  assign phase_next = phase_reg + NS_STEP;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pstate_reg <= PS_IDLE;
      phase_reg  <= ZERO_RESET;
      level_reg  <= 1'b0;
    end else if (stop_req) begin
      pstate_reg <= PS_IDLE;
      phase_reg  <= ZERO_RESET;
    end else if (start_req) begin
      pstate_reg <= PS_WAIT;
      phase_reg  <= ZERO_RESET;
    end else begin
      unique case (pstate_reg)
        PS_IDLE: begin
          phase_reg <= ZERO_RESET;
        end
        PS_WAIT: begin
          // Start value is compared within the current second only; one
          // at or past the one-second compare never fires
          if (adv && nanosecond_count_reg >= pulse_start_value_reg) begin
            pstate_reg <= PS_RUN;
            level_reg  <= 1'b1;
            phase_reg  <= ZERO_RESET;
          end
        end
        PS_RUN: begin
          if (adv) begin
            // Periods below one step still give one tick per phase
            if (phase_next >= (level_reg ? pulse_high_period_reg
                                         : pulse_low_period_reg)) begin
              level_reg <= !level_reg;
              phase_reg <= ZERO_RESET;
            end else begin
              phase_reg <= phase_next;
            end
          end
        end
        default: begin
          pstate_reg <= PS_IDLE;
        end
      endcase
    end
  end

  // Idle level as it stands after this edge; a config write that also
  // carries the stop bit outside the idle state shows the old level, not its new one
  always_comb begin
    idle_next = pulse_idle_level_reg;
    if (wr_cfg && pstate_reg == PS_IDLE)
      idle_next = reg_wdata[CFG_IDLE];
  end

  // Idle level shows at once when not running
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      periodic_pulse_output <= 1'b0;
    else if (stop_req)
      periodic_pulse_output <= idle_next;
    else if (pstate_reg == PS_RUN)
      periodic_pulse_output <= level_reg;
    else
      periodic_pulse_output <= idle_next;
  end

  // Read port; config write-only and reserved bits read zero; capture-high reads the stamp, not the size select bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= ZERO_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ONE_SEC:  reg_rdata <= one_second_compare_reg;
        ADDR_SEC_CNT:  reg_rdata <= seconds_count_reg;
        ADDR_NS_CNT:   reg_rdata <= nanosecond_count_reg;
        ADDR_CFG:      reg_rdata <= {27'h0000000,
                                     capture_freerun_select_reg,
                                     1'b0, pulse_idle_level_reg,
                                     1'b0,
                                     stamp_counters_enable_reg};
        ADDR_HI_PER:   reg_rdata <= pulse_high_period_reg;
        ADDR_LO_PER:   reg_rdata <= pulse_low_period_reg;
        ADDR_START:    reg_rdata <= pulse_start_value_reg;
        ADDR_FREE_CNT: reg_rdata <= freerun_reg;
        ADDR_CAPT_LO:  reg_rdata <= stamp_value[31:0];
        ADDR_CAPT_HI:  reg_rdata <= stamp_value[63:32];
        default:       reg_rdata <= ZERO_RESET;
      endcase
    end else begin
      reg_rdata <= ZERO_RESET;
    end
  end

  // Frame stamp size is set by bit 0 of a write to the capture-high address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      frame_stamp_size_select_reg <= 1'b0;
    else if (hit(reg_addr, ADDR_CAPT_HI, reg_wr))
      frame_stamp_size_select_reg <= reg_wdata[0];
  end
endmodule // ptc_timer
`default_nettype wire

// ---- sim/ptc_timer_sva.sv ----
// Checker on the time counter register, stamp and pulse ports
`timescale 1ns/1ps
`default_nettype none
module ptc_timer_sva
  import ptc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        frame_rx,
  input wire logic        stamp_valid,
  input wire logic        stamp_wide,
  input wire logic [63:0] stamp_value,
  input wire logic        periodic_pulse_output
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic       en_reg;
  logic       size_reg;
  logic       stopped_reg;
  logic [3:0] quiet_reg;
  wire cfg_wr = reg_wr && reg_addr == ADDR_CFG;
  wire stop_wr = cfg_wr && reg_wdata[CFG_STOP];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      en_reg <= 1'b0;
      size_reg <= 1'b0;
    end else if (cfg_wr) begin
      en_reg <= reg_wdata[CFG_ENABLE];
    end else if (reg_wr && reg_addr == ADDR_CAPT_HI) begin
      size_reg <= reg_wdata[0];
    end
  end
  // Pulse idle from reset until a start-time write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stopped_reg <= 1'b1;
      quiet_reg <= 4'h0;
    end else if (stop_wr) begin
      stopped_reg <= 1'b1;
      quiet_reg <= 4'h1;
    end else if (reg_wr) begin
      stopped_reg <= stopped_reg && reg_addr != ADDR_START;
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'h0 && quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  a_cfg_reserved: assert property (
    $past(reg_rd && reg_addr == ADDR_CFG)
    |-> reg_rdata[31:5] == '0 && !reg_rdata[3] && !reg_rdata[1])
    else $error("config read shows reserved or write-only bits");
  a_stamp_cause: assert property (
    stamp_valid |-> $past(frame_rx && en_reg))
    else $error("stamp without an enabled frame");
  a_stamp_follow: assert property (
    frame_rx && en_reg |=> stamp_valid)
    else $error("enabled frame not stamped");
  a_wide_select: assert property (
    stamp_valid |-> stamp_wide == $past(size_reg))
    else $error("stamp format differs from size select");
  a_stamp_narrow: assert property (
    stamp_valid && !stamp_wide |-> stamp_value[63:32] == '0)
    else $error("narrow stamp has upper word set");
  a_stamp_hold: assert property (
    !stamp_valid |-> $stable(stamp_value))
    else $error("stamp changed without a frame");
  a_stop_quiet: assert property (
    quiet_reg > 4'h1 |-> $stable(periodic_pulse_output))
    else $error("pulse output moved after a stop");
  a_idle_follow: assert property (
    stopped_reg && cfg_wr
    |=> periodic_pulse_output == $past(reg_wdata[CFG_IDLE]))
    else $error("idle output does not follow idle level");
endmodule // ptc_timer_sva
bind ptc_timer ptc_timer_sva u_sva (.mclk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .frame_rx, .stamp_valid, .stamp_wide,
  .stamp_value, .periodic_pulse_output);
`default_nettype wire

// ---- sim/test_ptc_timer.sv ----
// Self-checking bench for the time counter and pulse output
`timescale 1ns/1ps
`default_nettype none
module test_ptc_timer;
  import ptc_pkg::*;
  logic        mclk, resetn, reg_wr, reg_rd, frame_rx, pout, sv, sw;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, t, s0, n0, d;
  logic [63:0] stamp_value;
  int fail_count = 0, num_checks = 0, cyc = 0, seed = 32'he80dc136;
  int k, c;
  ptc_timer dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_rx(frame_rx), .stamp_valid(sv),
    .stamp_wide(sw), .stamp_value(stamp_value),
    .periodic_pulse_output(pout));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run;
    end
  end
  task automatic chk(input logic [63:0] g, e0, e1, input string m);
    num_checks++;
    if (g !== e0 && g !== e1) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask
  task automatic near(input logic [31:0] g, input int e, input string m);
    num_checks++;
    if ((g + 3 >= e && g <= e + 3) !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s got %0d", $time, m, g);
    end
  endtask
  // A spare cycle after each strobe keeps every driver edge single
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic wait_lvl(input logic v);
    c = 0;
    while (pout !== v && c < 400) begin
      @(negedge mclk);
      c++;
    end
    @(posedge mclk);
  endtask
  function automatic logic [63:0] exp_stamp(int m, logic [31:0] s, n, tk);
    logic [63:0] tot;
    tot = n + 64'd16 * tk;
    s = s + 32'(tot / 64'h100);
    tot = tot % 64'h100;
    return m == 0 ? {s, tot[31:0]} : m == 1 ? {32'h0, tk}
                  : {32'h0, s[1:0], tot[29:0]};
  endfunction
  initial begin
    {reg_wr, reg_rd, frame_rx, reg_addr, reg_wdata} = '0;
    resetn = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int a = 'h81; a <= 'h86; a++) begin
      rd(8'(a));
      d = a == 'h81 ? ONE_SEC_RESET : ZERO_RESET;
      chk(rv, d, d, "reset");
    end
    for (int a = 'h80; a <= 'h86; a++) begin
      d = ($random(seed) & 32'hfffffff0) | 32'h10;
      if (a == 'h84) continue;
      wr(8'(a), d);
      rd(8'(a));
      if (a == 'h80) d = 32'h00000000;
      chk(rv, d, d, "readback");
    end
    wr(ADDR_CFG, 32'hfffffffe);
    chk(pout, 1, 1, "idle level");
    rd(ADDR_CFG);
    chk(rv, 32'h14, 32'h14, "config");
    wr(ADDR_CFG, 32'h0);
    $display("test registers done");
    wr(ADDR_ONE_SEC, 32'h100);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CFG, 32'h2);
      rd(ADDR_FREE_CNT);
      chk(rv, 0, 0, "clear");
      s0 = $random(seed);
      n0 = $random(seed) & 32'hf0;
      wr(ADDR_SEC_CNT, s0);
      wr(ADDR_NS_CNT, n0);
      wr(ADDR_CAPT_HI, 32'(m == 0));
      wr(ADDR_CFG, m == 1 ? 32'h11 : 32'h1);
      k = 100 + ($random(seed) & 255);
      for (int i = 0; i < k; i++) begin
        frame_rx <= ($random(seed) & 3) == 0;
        @(posedge mclk);
      end
      frame_rx <= 1'b1;
      reg_addr <= ADDR_CFG;
      reg_wdata <= m == 1 ? 32'h10 : 32'h0;
      reg_wr <= 1'b1;
      @(posedge mclk);
      {frame_rx, reg_wr} <= 2'b00;
      @(posedge mclk);
      rd(ADDR_FREE_CNT);
      t = rv;
      near(t, (k + 2) * 3 / 5, "tick rate");
      chk(stamp_value, exp_stamp(m, s0, n0, t),
          exp_stamp(m, s0, n0, t - 1), "stamp");
      repeat (20) @(posedge mclk);
      rd(ADDR_FREE_CNT);
      chk(rv, t, t, "frozen");
      $display("test stamp mode %0d done", m);
    end
    wr(ADDR_HI_PER, 32'd480);
    wr(ADDR_LO_PER, 32'd960);
    wr(ADDR_CFG, 32'h3);
    wr(ADDR_START, 32'h10);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    near(c, 50, "high period");
    wait_lvl(1'b1);
    near(c, 100, "low period");
    wr(ADDR_CFG, 32'hd);
    chk(pout, 0, 0, "stop");
    rd(ADDR_CFG);
    chk(rv, 32'h1, 32'h1, "idle level kept");
    repeat (200) @(posedge mclk);
    chk(pout, 0, 0, "stays stopped");
    wr(ADDR_START, 32'h10);
    wait_lvl(1'b1);
    chk(pout, 1, 1, "restart");
    wait_lvl(1'b0);
    near(c, 50, "restart high period");
    $display("test pulse done");
    complete_run;
  end
endmodule // test_ptc_timer
`default_nettype wire
